// ==== design/tec_timer.sv ====
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - read-only 16-bit counter, counts selected clock
// - read while running returns instant value
// - reset forces counter to zero
// - both upper mode bits zero clears counter
// - edge-clear mode zeroes on primary trigger edge
// - match-clear mode zeroes on first compare match
// - control bit 0 selects capture or compare
// - compare match raises first match interrupt
// - first register sets interval period
// - capture trigger from primary or secondary edge
// - edge code 00 fall, 01 rise, 11 both
// - primary-triggered first capture uses opposite edge
// - counting runs while any upper bit set
// - mode field: stop, free, edge-clear, match-clear
// - overflow flag on wrap from all ones
// - second register compare raises own interrupt
module tec_timer
  import tec_pkg::*;
#(
  parameter int DIV_W = 4 // width of the internal prescale divider
) (
  input wire logic aclk, // system clock 10 MHz
  input wire logic aresetn, // synchronous reset, low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic primary_trigger_input, // first trigger pin
  input wire logic secondary_trigger_input, // second trigger pin
  output logic irq // level interrupt
);
  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] timer_count_value_q; // the counter
  logic [15:0] capture_compare_first_q; // first capture/compare
  logic [15:0] capture_compare_second_q; // second capture/compare
  logic [3:0] timer_mode_control_q; // op mode bits and overflow flag
  logic [2:0] capture_compare_control_q; // capture selects
  logic [7:0] prescaler_mode_control_q; // edge selects, clock source
  logic [TEC_IRQ_W-1:0] irq_stat_q; // sticky events
  logic [TEC_IRQ_W-1:0] irq_mask_q; // interrupt enables
  logic [DIV_W-1:0] div_q; // prescale divider
  tec_mode_t mode; // decoded operating mode
  logic running; // counter enabled
  logic tick; // count clock enable
  logic ext_tick; // rising primary edge as event clock
  logic hold; // count held off for a read
  logic cnt_en; // increment this cycle
  logic m1, m2; // compare matches
  logic wrap; // increment from all ones
  logic clr_edge, clr_match; // clear causes
  logic cap1, cap2; // capture strobes
  logic prim_valid, sec_valid; // valid edges per select field
  logic prim_opp; // opposite edge of primary select
  logic wr_go, rd_go; // bus accesses taken this cycle
  logic [7:0] wa, ra; // byte addresses in use
  logic [31:0] rd_d; // read mux
  logic rd_err; // unmapped read
  logic [TEC_IRQ_W-1:0] ev; // new events
  logic clr_stat; // status read clears
  logic wr_mode; // mode register written
  logic stop_wr; // write that stops the counter
  logic [31:0] wd_q; // write data held until it is applied
  logic wstb_q; // low-lane strobe held with the data

  tec_edge_if prim_ev ();
  tec_edge_if sec_ev ();

  // the trigger pins are synchronised before any edge is used
  tec_edge_det u_prim (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(primary_trigger_input),
    .ev(prim_ev.src)
  );
  tec_edge_det u_sec (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(secondary_trigger_input),
    .ev(sec_ev.src)
  );

  // decide whether an edge pair matches a two-bit select code
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic r, input logic f);
    case (sel)
      TEC_ES_FALL: edge_hit = f;
      TEC_ES_RISE: edge_hit = r;
      TEC_ES_BOTH: edge_hit = r | f;
      default: edge_hit = 1'b0; // forbidden code does nothing
    endcase
  endfunction : edge_hit

  //////////////////////////////////////////////////////////////////////////
  // mode decode and count enable
  always_comb begin
    case (timer_mode_control_q[TEC_MODE_OP_HI:TEC_MODE_OP_LO])
      2'h0: mode = TEC_STOP;
      2'h1: mode = TEC_FREE;
      2'h2: mode = TEC_CLR_EDGE;
      default: mode = TEC_CLR_MATCH;
    endcase
  end
  assign running = (mode != TEC_STOP);

  assign prim_valid = edge_hit(
    prescaler_mode_control_q[TEC_ES0_LO+:2], prim_ev.rise, prim_ev.fall);
  assign sec_valid = edge_hit(
    prescaler_mode_control_q[TEC_ES1_LO+:2], sec_ev.rise, sec_ev.fall);
  // opposite edge: falling select captures on rise and vice versa
  assign prim_opp =
    (prescaler_mode_control_q[TEC_ES0_LO+:2] == TEC_ES_FALL) ? prim_ev.rise :
    (prescaler_mode_control_q[TEC_ES0_LO+:2] == TEC_ES_RISE) ? prim_ev.fall :
    1'b0;

  // rising count edge: every cycle, divider roll-over, or event pin
  assign ext_tick = prim_ev.rise;
  always_comb begin
    case (prescaler_mode_control_q[TEC_CLKSEL_LO+:2])
      TEC_CLK_SYS: tick = 1'b1;
      TEC_CLK_DIV: tick = &div_q;
      TEC_CLK_EXT: tick = ext_tick;
      default: tick = 1'b0;
    endcase
  end

  // a read of the counter takes its value this cycle; the hold keeps the
  // increment out of that cycle, and the tick is deferred, never dropped.
  // a count on every system clock leaves no gap to take a held tick back,
  // so there is no hold then: the read already takes the pre-edge value
  assign hold = rd_go && (ra == TEC_OFF_COUNT) &&
    (prescaler_mode_control_q[TEC_CLKSEL_LO+:2] != TEC_CLK_SYS);
  logic pend_q; // deferred tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= running & hold & (tick | pend_q);
    end
  end
  assign cnt_en = running & ~hold & (tick | pend_q);

  // divider for the slow count clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare, clear and capture
  assign m1 = running & ~capture_compare_control_q[TEC_CC1_CAP_BIT]
    & (timer_count_value_q == capture_compare_first_q) & cnt_en;
  assign m2 = running & ~capture_compare_control_q[TEC_CC2_CAP_BIT]
    & (timer_count_value_q == capture_compare_second_q) & cnt_en;
  assign wrap = cnt_en & (timer_count_value_q == TEC_CNT_MAX);
  assign clr_edge = (mode == TEC_CLR_EDGE) & prim_valid;
  assign clr_match = (mode == TEC_CLR_MATCH) & m1;
  assign cap1 = capture_compare_control_q[TEC_CC1_CAP_BIT] & running &
    (capture_compare_control_q[TEC_CC1_SRC_BIT] ? sec_valid : prim_opp);
  assign cap2 = capture_compare_control_q[TEC_CC2_CAP_BIT] & running &
    prim_valid;
  assign wr_mode = wr_go && (wa == TEC_OFF_MODE);
  assign stop_wr = wr_mode && wstb_q &&
    (wd_q[TEC_MODE_OP_HI:TEC_MODE_OP_LO] == 2'h0);

  // the counter itself; software cannot write it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count_value_q <= TEC_CNT_ZERO;
    end else if (!running || stop_wr) begin
      timer_count_value_q <= TEC_CNT_ZERO;
    end else if (clr_edge || clr_match) begin
      timer_count_value_q <= TEC_CNT_ZERO;
    end else if (cnt_en) begin
      timer_count_value_q <= timer_count_value_q + 1'b1;
    end
  end

  // first capture/compare: captures take the current count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_compare_first_q <= TEC_CNT_ZERO;
    end else if (cap1) begin
      capture_compare_first_q <= timer_count_value_q;
    end else if (wr_go && wa == TEC_OFF_CC1 && wstb_q) begin
      capture_compare_first_q <= wd_q[15:0];
    end
  end

  // second capture/compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_compare_second_q <= TEC_CNT_ZERO;
    end else if (cap2) begin
      capture_compare_second_q <= timer_count_value_q;
    end else if (wr_go && wa == TEC_OFF_CC2 && wstb_q) begin
      capture_compare_second_q <= wd_q[15:0];
    end
  end

  // mode register; overflow flag set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_control_q <= 4'h0;
    end else begin
      if (wr_mode && wstb_q) begin
        timer_mode_control_q[3:1] <= wd_q[3:1];
        timer_mode_control_q[TEC_MODE_OVF_BIT] <=
          wd_q[TEC_MODE_OVF_BIT] | wrap;
      end else if (wrap) begin
        timer_mode_control_q[TEC_MODE_OVF_BIT] <= 1'b1;
      end
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_compare_control_q <= 3'h0;
      prescaler_mode_control_q <= 8'h00;
      irq_mask_q <= '0;
    end else if (wr_go && wstb_q) begin
      if (wa == TEC_OFF_CCCTL) begin
        capture_compare_control_q <= wd_q[2:0];
      end else if (wa == TEC_OFF_PRESC) begin
        prescaler_mode_control_q <= wd_q[7:0];
      end else if (wa == TEC_OFF_IRQMSK) begin
        irq_mask_q <= wd_q[TEC_IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, cleared by a read, new events win
  assign ev = {wrap, m2, m1};
  assign clr_stat = rd_go && (ra == TEC_OFF_IRQST);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (clr_stat ? '0 : irq_stat_q) | ev;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((clr_stat ? '0 : irq_stat_q) | ev) & irq_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite write: take address and data in either order, then respond
  logic aw_have_q, w_have_q; // halves held
  logic [7:0] aw_q; // latched address
  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wa = aw_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TEC_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q > TEC_OFF_IRQMSK || aw_q[1:0] != 2'h0 ||
          aw_q == TEC_OFF_COUNT || aw_q == TEC_OFF_IRQST) ?
          TEC_RESP_ERR : TEC_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // the write data is held in the slave until the register updates
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_q <= 32'h0000_0000;
      wstb_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wd_q <= s_axi_wdata; // the master may move wdata once it is taken
      wstb_q <= s_axi_wstrb[0];
    end
  end

  // axi4-lite read: one cycle address to data
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign ra = s_axi_araddr[7:0];
  assign s_axi_arready = ~s_axi_rvalid;
  always_comb begin
    rd_d = 32'h0000_0000;
    rd_err = 1'b0;
    if (ra == TEC_OFF_COUNT) begin
      rd_d[15:0] = timer_count_value_q;
    end else if (ra == TEC_OFF_CC1) begin
      rd_d[15:0] = capture_compare_first_q;
    end else if (ra == TEC_OFF_CC2) begin
      rd_d[15:0] = capture_compare_second_q;
    end else if (ra == TEC_OFF_MODE) begin
      rd_d[3:0] = timer_mode_control_q;
    end else if (ra == TEC_OFF_CCCTL) begin
      rd_d[2:0] = capture_compare_control_q;
    end else if (ra == TEC_OFF_PRESC) begin
      rd_d[7:0] = prescaler_mode_control_q;
    end else if (ra == TEC_OFF_IRQST) begin
      rd_d[TEC_IRQ_W-1:0] = irq_stat_q;
    end else if (ra == TEC_OFF_IRQMSK) begin
      rd_d[TEC_IRQ_W-1:0] = irq_mask_q;
    end else begin
      rd_err = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TEC_RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_err ? TEC_RESP_ERR : TEC_RESP_OK;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : tec_timer
`default_nettype wire

// ==== common/tec_pkg.sv ====
package tec_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] TEC_OFF_COUNT = 8'h00;
  localparam logic [7:0] TEC_OFF_CC1 = 8'h04;
  localparam logic [7:0] TEC_OFF_CC2 = 8'h08;
  localparam logic [7:0] TEC_OFF_MODE = 8'h0c;
  localparam logic [7:0] TEC_OFF_CCCTL = 8'h10;
  localparam logic [7:0] TEC_OFF_PRESC = 8'h14;
  localparam logic [7:0] TEC_OFF_IRQST = 8'h18;
  localparam logic [7:0] TEC_OFF_IRQMSK = 8'h1c;
  // mode register fields
  localparam int TEC_MODE_OVF_BIT = 0;
  localparam int TEC_MODE_OP_LO = 2;
  localparam int TEC_MODE_OP_HI = 3;
  // capture/compare control fields
  localparam int TEC_CC1_CAP_BIT = 0;
  localparam int TEC_CC1_SRC_BIT = 1;
  localparam int TEC_CC2_CAP_BIT = 2;
  // prescaler mode fields: primary edge select, secondary edge select, clock source select
  localparam int TEC_ES0_LO = 4;
  localparam int TEC_ES1_LO = 6;
  localparam int TEC_CLKSEL_LO = 0;
  // interrupt status bits
  localparam int TEC_IRQ_M1 = 0;
  localparam int TEC_IRQ_M2 = 1;
  localparam int TEC_IRQ_OVF = 2;
  localparam int TEC_IRQ_W = 3;
  // edge select codes
  localparam logic [1:0] TEC_ES_FALL = 2'h0;
  localparam logic [1:0] TEC_ES_RISE = 2'h1;
  localparam logic [1:0] TEC_ES_BOTH = 2'h3;
  // count clock sources
  localparam logic [1:0] TEC_CLK_SYS = 2'h0;
  localparam logic [1:0] TEC_CLK_DIV = 2'h1;
  localparam logic [1:0] TEC_CLK_EXT = 2'h2;
  localparam logic [15:0] TEC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TEC_CNT_MAX = 16'hffff;
  localparam logic [1:0] TEC_RESP_OK = 2'h0;
  localparam logic [1:0] TEC_RESP_ERR = 2'h2;
  typedef enum logic [1:0] {TEC_STOP, TEC_FREE, TEC_CLR_EDGE, TEC_CLR_MATCH}
    tec_mode_t;
endpackage : tec_pkg

// ==== common/tec_edge_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// edge events of one synchronised trigger pin
interface tec_edge_if;
  logic rise; // one-cycle pulse on rising edge
  logic fall; // one-cycle pulse on falling edge
  modport src (output rise, fall);
  modport dst (input rise, fall);
endinterface : tec_edge_if
`default_nettype wire

// ==== design/tec_edge_det.sv ====
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser followed by an edge detector
module tec_edge_det
  import tec_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic pin, // raw trigger pin
  tec_edge_if.src ev // edge pulses
);
  logic meta_q; // first stage, read only by sync_q
  logic sync_q; // second stage
  logic prev_q; // last synchronised level

  // synchronise the pin; the first stage feeds nothing else
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // each edge produces exactly one pulse
  assign ev.rise = sync_q & ~prev_q;
  assign ev.fall = ~sync_q & prev_q;
endmodule : tec_edge_det
`default_nettype wire

// ==== verification/tec_trig_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// far side: drives the two trigger pins as levels
module tec_trig_model (
  input wire logic aclk, // system clock
  output logic prim, // primary trigger pin
  output logic sec // secondary trigger pin
);
  // both pins idle low from time zero
  initial begin
    prim = 1'b0;
    sec = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // each level stands four edges, past the three-edge sync latency, so
  // every edge is seen once and no pulse is too short to be caught
  task automatic level(input bit p, input logic v);
    if (p) begin
      prim <= v;
    end else begin
      sec <= v;
    end
    repeat (4) @(posedge aclk);
  endtask : level
  // n whole high-low pulses on the primary pin
  task automatic pulse(input int n);
    repeat (n) begin
      level(1'b1, 1'b1);
      level(1'b1, 1'b0);
    end
  endtask : pulse
endmodule : tec_trig_model
`default_nettype wire

// ==== verification/tec_timer_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
// bus and interrupt relations seen at the timer's ports
module tec_timer_chk
  import tec_pkg::*;
#(
  parameter int DIV_W = 4 // divider width of the timer
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic irq // interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  chk_wresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_lat: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_count_ro: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr[7:0] == TEC_OFF_COUNT |=> ##1 s_axi_bresp == TEC_RESP_ERR)
    else $error("count write accepted");
  chk_unmapped_rd: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] > TEC_OFF_IRQMSK
    |=> s_axi_rresp == TEC_RESP_ERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_irq_reset: assert property (
    $rose(aresetn) |-> !irq)
    else $error("interrupt high out of reset");
  chk_bus_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken before response");
endmodule : tec_timer_chk
bind tec_timer tec_timer_chk #(.DIV_W(DIV_W)) u_chk (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .irq);
`default_nettype wire

// ==== verification/test_tec_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
// register-level tests of the timer/event counter
module test_tec_timer;
  import tec_pkg::*;
  logic aclk, aresetn; // clock and reset
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb; // write strobes
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq; // design outputs
  logic [1:0] s_axi_bresp, s_axi_rresp; // responses
  wire prim, sec; // trigger pins from the model
  int miscompares = 0; // mismatches
  int samples_checked = 0; // comparisons
  int n; // wait counter
  tec_timer #(.DIV_W(4)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .primary_trigger_input(prim),
    .secondary_trigger_input(sec), .irq);
  tec_trig_model trig (.aclk, .prim, .sec);
  // 10 mhz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check_data(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check_data
  task automatic check_resp(input string nm, input logic [1:0] e,
                            input logic [1:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check_resp
  // one write; each valid drops at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 100);
    if (s_axi_bvalid !== 1'b1) miscompares++;
    s_axi_bready <= 1'b0;
    check_resp($sformatf("bresp %h", a), er, s_axi_bresp);
  endtask : wr
  // one read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 100);
    if (s_axi_rvalid !== 1'b1) miscompares++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // read a mapped register and compare it
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check_resp($sformatf("rresp %h", a), TEC_RESP_OK, r);
    check_data($sformatf("reg %h", a), e, d);
  endtask : rc
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////
  // watchdog: the overflow wait dominates the run
  initial begin
    repeat (90000) @(posedge aclk);
    miscompares++;
    give_verdict();
  end
  // main sequence
  initial begin : main
    logic [31:0] d;
    logic [1:0] r;
    aresetn = 1'b0;
    s_axi_awaddr = 32'h0000_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_araddr = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(TEC_OFF_COUNT, 32'h0000_0000);
    rc(TEC_OFF_MODE, 32'h0000_0000);
    check_data("irq", 32'h0000_0000, 32'(irq));
    wr(TEC_OFF_COUNT, 32'h0000_1234, TEC_RESP_ERR);
    rc(TEC_OFF_COUNT, 32'h0000_0000);
    rd(8'h40, d, r);
    check_resp("unmapped", TEC_RESP_ERR, r);
    // count primary rising edges, clear edge is falling
    wr(TEC_OFF_PRESC, 32'(TEC_CLK_EXT), TEC_RESP_OK);
    wr(TEC_OFF_MODE, 32'h0000_0004, TEC_RESP_OK);
    trig.pulse(5);
    rc(TEC_OFF_COUNT, 32'h0000_0005);
    rc(TEC_OFF_IRQST, 32'h0000_0003);
    wr(TEC_OFF_MODE, 32'h0000_0000, TEC_RESP_OK);
    rc(TEC_OFF_COUNT, 32'h0000_0000);
    // compare matches on both registers raise the interrupt
    wr(TEC_OFF_CC1, 32'h0000_0003, TEC_RESP_OK);
    wr(TEC_OFF_CC2, 32'h0000_0002, TEC_RESP_OK);
    wr(TEC_OFF_IRQMSK, 32'h0000_0003, TEC_RESP_OK);
    check_data("irq", 32'h0000_0000, 32'(irq));
    wr(TEC_OFF_MODE, 32'h0000_0004, TEC_RESP_OK);
    trig.pulse(4);
    check_data("irq", 32'h0000_0001, 32'(irq));
    rc(TEC_OFF_IRQST, 32'h0000_0003);
    repeat (2) @(posedge aclk);
    check_data("irq", 32'h0000_0000, 32'(irq));
    wr(TEC_OFF_MODE, 32'h0000_0000, TEC_RESP_OK);
    // match-clear gives a period of cc+1 ticks
    wr(TEC_OFF_CC1, 32'h0000_0002, TEC_RESP_OK);
    wr(TEC_OFF_MODE, 32'h0000_000c, TEC_RESP_OK);
    trig.pulse(7);
    rc(TEC_OFF_COUNT, 32'h0000_0001);
    wr(TEC_OFF_MODE, 32'h0000_0000, TEC_RESP_OK);
    // edge-clear: rise counts, valid falling edge clears
    wr(TEC_OFF_MODE, 32'h0000_0008, TEC_RESP_OK);
    trig.pulse(3);
    rc(TEC_OFF_COUNT, 32'h0000_0000);
    wr(TEC_OFF_MODE, 32'h0000_0000, TEC_RESP_OK);
    // captures: first from secondary, second on primary falling
    wr(TEC_OFF_CCCTL, 32'h0000_0007, TEC_RESP_OK);
    wr(TEC_OFF_PRESC, 32'h0000_0042, TEC_RESP_OK);
    wr(TEC_OFF_MODE, 32'h0000_0004, TEC_RESP_OK);
    trig.pulse(3);
    rc(TEC_OFF_CC2, 32'h0000_0003);
    trig.level(1'b0, 1'b1);
    trig.level(1'b0, 1'b0);
    rc(TEC_OFF_CC1, 32'h0000_0003);
    rc(TEC_OFF_COUNT, 32'h0000_0003);
    // primary source: opposite edge, none when both selected
    wr(TEC_OFF_CCCTL, 32'h0000_0005, TEC_RESP_OK);
    wr(TEC_OFF_PRESC, 32'h0000_0012, TEC_RESP_OK);
    trig.pulse(2);
    rc(TEC_OFF_CC1, 32'h0000_0005);
    wr(TEC_OFF_PRESC, 32'h0000_0032, TEC_RESP_OK);
    trig.pulse(1);
    rc(TEC_OFF_CC1, 32'h0000_0005);
    rc(TEC_OFF_CC2, 32'h0000_0006);
    // a write without the low byte lane leaves the register alone
    s_axi_wstrb <= 4'he;
    wr(TEC_OFF_CC1, 32'h0000_00ff, TEC_RESP_OK);
    s_axi_wstrb <= 4'hf;
    rc(TEC_OFF_CC1, 32'h0000_0005);
    wr(TEC_OFF_MODE, 32'h0000_0000, TEC_RESP_OK);
    // free run on the system clock until the counter wraps
    wr(TEC_OFF_PRESC, 32'h0000_0000, TEC_RESP_OK);
    wr(TEC_OFF_CCCTL, 32'h0000_0000, TEC_RESP_OK);
    wr(TEC_OFF_IRQMSK, 32'h0000_0004, TEC_RESP_OK);
    wr(TEC_OFF_MODE, 32'h0000_0004, TEC_RESP_OK);
    // count starts at the response edge; reads in flight lose no count
    rc(TEC_OFF_COUNT, 32'h0000_0002);
    rc(TEC_OFF_COUNT, 32'h0000_0005);
    n = 0;
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge aclk);
      n++;
    end
    check_data("ovf irq", 32'h0000_0001, 32'(irq));
    rc(TEC_OFF_MODE, 32'h0000_0005);
    give_verdict();
  end
endmodule : test_tec_timer
`default_nettype wire
